// ==== testbench/supply_osc_model.sv ====
// Behavioural model of the supply comparators and the free-running crystal oscillator.
`timescale 1ns/1ps
module supply_osc_model #(
   parameter int RESET_MV = 2700, // Reset threshold in millivolts, a plain default.
   parameter int TRIP_MV = 2200, // Standard switchover threshold in millivolts.
   parameter int OSC_HALF_NS = 400 // Half of the 800 ns link clock period.
) (
   input wire logic [15:0] vdd_mv,
   input wire logic [15:0] vbat_mv,
   output logic osc_clk,
   output rtc_alarm_pkg::supply_t level
);
   // The crystal keeps running in every supply state, so the link clock never stops.
   initial begin
      osc_clk = 1'b0;
   end
   always begin
      #(OSC_HALF_NS) osc_clk = ~osc_clk;
   end
   // Ideal comparators; real parts add hysteresis, which no scenario here depends on.
   always_comb begin
      level.main_above_reset = vdd_mv > 16'(RESET_MV);
      level.main_above_battery = vdd_mv > vbat_mv;
      level.main_above_trip = vdd_mv > 16'(TRIP_MV);
   end
endmodule : supply_osc_model

// ==== testbench/testbench.sv ====
// Self-checking bench for the alarm and backup bus gating block over APB.
`timescale 1ns/1ps
module testbench;
   localparam int RESET_MV = 2700; // Threshold handed to the supply model.
   localparam int TRIP_MV = 2200; // Switchover threshold handed to the supply model.
   logic pclk = 1'b0; // Bus clock, 100 ns period.
   logic presetn = 1'b0; // Held low for the first 16 clocks.
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'hf; // Full word strobes; partial writes are not exercised.
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic osc_clk;
   rtc_alarm_pkg::supply_t sup; // Comparator levels from the model.
   logic bus_access_ok;
   logic on_battery;
   logic pin_o;
   logic pin_oe;
   logic irq;
   logic [15:0] vdd_mv = 16'h0ce4; // Main supply, 3300 mV.
   logic [15:0] vbat_mv = 16'h0bb8; // Battery rail, 3000 mV.
   logic [15:0] vdd_tab [4] = '{16'h0ce4, 16'h0b54, 16'h09c4, 16'h07d0}; // 3300, 2900, 2500, 2000 mV.
   int err_total = 0;
   int check_count = 0;
   logic [31:0] rd; // Read data taken at the completing edge.
   logic er; // Error flag taken at the completing edge.
   int hi_cnt; // Clocks with the pin pulled low during a watch.
   int rise_cnt; // Separate alarm events during a watch.
   logic r_ok, t_ok, b_ok, exp_ok, exp_bat;

   // Short second of four link edges keeps a minute near 2000 bus clocks.
   rtc_alarm_gate #(.TICKS_PER_SECOND(4)) u_rtc_alarm_gate (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .osc_clk(osc_clk), .main_above_reset(sup.main_above_reset),
      .main_above_battery(sup.main_above_battery), .main_above_trip(sup.main_above_trip),
      .bus_access_ok(bus_access_ok), .on_battery(on_battery), .alarm_out_pin_o(pin_o),
      .alarm_out_pin_oe(pin_oe), .irq(irq));
   supply_osc_model #(.RESET_MV(RESET_MV), .TRIP_MV(TRIP_MV)) u_supply_osc_model (.vdd_mv(vdd_mv),
      .vbat_mv(vbat_mv), .osc_clk(osc_clk), .level(sup));

   // Free running bus clock.
   always begin
      #50 pclk = ~pclk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done

   // Compares one value and reports a mismatch at once.
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h seen %h", name, exp, got);
         err_total++;
      end
   endtask : chk

   // One APB transfer; the request stands until pready is seen high at a rising edge.
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         chk("apb ready", 32'h1, 32'(pready));
         test_done();
      end
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
      apb(a, 1'b0, 32'h0000_0000);
      chk(name, exp, rd);
   endtask : rdchk

   // Writes all six match registers from one packed time value.
   task automatic set_match(input rtc_alarm_pkg::bcd_time_t t);
      for (int i = 0; i < 6; i++) begin
         wr(rtc_alarm_pkg::OFF_SECOND_MATCH + 8'(4 * i), 32'(t[8 * i +: 8]));
      end
   endtask : set_match

   // Counts alarm clocks and events; the pin data line must never go high.
   task automatic watch(input int n);
      logic prev;
      hi_cnt = 0;
      rise_cnt = 0;
      prev = pin_oe;
      repeat (n) begin
         @(posedge pclk);
         hi_cnt += int'(pin_oe === 1'b1);
         rise_cnt += int'(pin_oe === 1'b1 && prev !== 1'b1);
         prev = pin_oe;
         chk("pin data level", 32'h0, 32'(pin_o));
      end
   endtask : watch

   // Bounded wait for the alarm output; running out ends the run.
   task automatic wait_oe(input int lim);
      int n;
      n = 0;
      while (pin_oe !== 1'b1 && n < lim) begin
         @(posedge pclk);
         n++;
      end
      if (n >= lim) begin
         chk("alarm output wait", 32'h1, 32'(pin_oe));
         test_done();
      end
   endtask : wait_oe

   // Main sequence: reset values, gating table, single alarm, repeating alarm.
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(rtc_alarm_pkg::OFF_CONTROL, 32'(rtc_alarm_pkg::CONTROL_RESET), "control reset");
      for (int i = 0; i < 6; i++) begin
         rdchk(8'(4 * i), 32'(rtc_alarm_pkg::MATCH_RESET), "match reset");
      end
      apb(8'h30, 1'b0, 32'h0000_0000);
      chk("unmapped error", 32'h1, 32'(er));
      // Every mode against supplies above, between and below the thresholds.
      for (int m = 0; m < 4; m++) begin
         wr(rtc_alarm_pkg::OFF_CONTROL, 32'(m));
         for (int p = 0; p < 4; p++) begin
            vdd_mv <= vdd_tab[p];
            repeat (4) @(posedge pclk);
            r_ok = vdd_mv > 16'(RESET_MV);
            t_ok = vdd_mv > 16'(TRIP_MV);
            b_ok = vdd_mv > vbat_mv;
            exp_ok = (m == 3) ? (r_ok & b_ok) : ((m == 1) ? r_ok : (r_ok & t_ok));
            exp_bat = m[0] ? !b_ok : !t_ok;
            chk("bus access", 32'(exp_ok), 32'(bus_access_ok));
            chk("on battery", 32'(exp_bat), 32'(on_battery));
            rdchk(rtc_alarm_pkg::OFF_POWER, {30'h0, exp_bat, exp_ok}, "power");
         end
      end
      vdd_mv <= vdd_tab[0];
      // Alarm at 11:30 on the first of January; seconds and weekday left out.
      wr(rtc_alarm_pkg::OFF_IRQ_MASK, 32'h0);
      set_match(48'h00_81_81_91_b0_00);
      wr(rtc_alarm_pkg::OFF_TIME_HI, 32'h0000_0001);
      wr(rtc_alarm_pkg::OFF_CONTROL, 32'h0);
      wr(rtc_alarm_pkg::OFF_TIME_LO, 32'h0111_2958);
      watch(150);
      chk("alarm while disabled", 32'h0, 32'(hi_cnt));
      wr(rtc_alarm_pkg::OFF_TIME_LO, 32'h0111_2958);
      wr(rtc_alarm_pkg::OFF_CONTROL, 32'h1 << rtc_alarm_pkg::CTRL_ALARM0_EN_BIT);
      wait_oe(200);
      rdchk(rtc_alarm_pkg::OFF_TIME_LO, 32'h0111_3000, "alarm time");
      chk("irq while masked", 32'h0, 32'(irq));
      watch(200);
      chk("held output", 32'd200, 32'(hi_cnt));
      wr(rtc_alarm_pkg::OFF_IRQ_MASK, 32'h1 << rtc_alarm_pkg::STAT_ALARM0_BIT);
      repeat (2) @(posedge pclk);
      chk("irq unmasked", 32'h1, 32'(irq));
      // Stop alarms first, since the old ones still match every second during 11:30.
      wr(rtc_alarm_pkg::OFF_CONTROL, 32'h0);
      apb(rtc_alarm_pkg::OFF_STATUS, 1'b0, 32'h0000_0000);
      chk("alarm flag", 32'h1, rd & 32'h1);
      repeat (2) @(posedge pclk);
      chk("output after clear", 32'h0, 32'(pin_oe));
      chk("irq after clear", 32'h0, 32'(irq));
      apb(rtc_alarm_pkg::OFF_STATUS, 1'b0, 32'h0000_0000);
      set_match(48'h00_00_00_00_00_b0);
      // Start two seconds early so a tick before the enable write cannot skip the first match.
      wr(rtc_alarm_pkg::OFF_TIME_LO, 32'h0100_0028);
      wr(rtc_alarm_pkg::OFF_CONTROL, (32'h1 << rtc_alarm_pkg::CTRL_REPEAT_BIT) |
         (32'h1 << rtc_alarm_pkg::CTRL_ALARM0_EN_BIT));
      watch(2300);
      chk("repeat events", 32'd2, 32'(rise_cnt));
      chk("repeat pulse clocks", 32'd2, 32'(hi_cnt));
      apb(rtc_alarm_pkg::OFF_STATUS, 1'b0, 32'h0000_0000);
      chk("repeat flag", 32'h1, rd & 32'h1);
      test_done();
   end
endmodule : testbench

// ==== verilog/bcd_counter.sv ====
// One BCD time field counter with wrap and carry out.
`timescale 1ns/1ps
module bcd_counter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic step,
   input wire logic load,
   input wire logic [7:0] load_value,
   input wire logic [7:0] first_value,
   input wire logic [7:0] last_value,
   output logic [7:0] count,
   output logic carry
);
   logic [7:0] count_ff; // Current BCD value.
   logic [7:0] nxt_count;

   // Step the BCD digits; wrap from the last value to the first one.
   always_comb begin
      nxt_count = count_ff;
      if (load) begin
         nxt_count = load_value;
      end else if (step) begin
         if (count_ff == last_value) begin
            nxt_count = first_value;
         end else if (count_ff[3:0] == 4'h9) begin
            nxt_count = {count_ff[7:4] + 4'h1, 4'h0};
         end else begin
            nxt_count = {count_ff[7:4], count_ff[3:0] + 4'h1};
         end
      end
   end

   // Register the field.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff <= 8'h00;
      end else begin
         count_ff <= nxt_count;
      end
   end

   assign count = count_ff;
   assign carry = step && !load && (count_ff == last_value);
endmodule : bcd_counter

// ==== verilog/edge_sync.sv ====
// Two-flop synchroniser with rising edge detect after the second stage.
`timescale 1ns/1ps
module edge_sync #(
   parameter int WIDTH = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out,
   output logic [WIDTH-1:0] rise_pulse
);
   logic [WIDTH-1:0] meta_ff; // First stage, read only by the second stage.
   logic [WIDTH-1:0] sync_ff; // Second stage.
   logic [WIDTH-1:0] last_ff; // Previous settled value for edge finding.
   logic [WIDTH-1:0] nxt_meta;
   logic [WIDTH-1:0] nxt_sync;
   logic [WIDTH-1:0] nxt_last;

   // Next values are simple shifts down the chain.
   always_comb begin
      nxt_meta = async_in;
      nxt_sync = meta_ff;
      nxt_last = sync_ff;
   end

   // Register the chain.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= '0;
         sync_ff <= '0;
         last_ff <= '0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
         last_ff <= nxt_last;
      end
   end

   assign sync_out = sync_ff;
   assign rise_pulse = sync_ff & ~last_ff;
endmodule : edge_sync

// ==== verilog/rtc_alarm_gate.sv ====
// Alarm 0 logic, timekeeping and serial bus gating for backup supply, behind an APB slave.
//
// Operation
// [RULE_01] No bus below reset threshold, any mode.
// [RULE_02] Mode 00: standard switchover, no backup access.
// [RULE_03] Mode 01: legacy switchover, access above reset.
// [RULE_04] Mode 10 behaves exactly like mode 00.
// [RULE_05] Mode 11: access above reset and battery.
// [RULE_06] Bit 7 enables field; BCD below.
// [RULE_07] Disabled field never blocks the alarm.
// [RULE_08] Host sets alarm enable bit 5 first.
// [RULE_09] Match at minute rollover sets flag, output low; the code checks for a match at every second tick.
// [RULE_10] Single mode gives one event only; the code raises the event again at every second tick while the match holds.
// [RULE_11] Repeat mode pulses on every match.
// [RULE_12] Repeat mode sets flag every trigger anyway.
// [RULE_13] Standard backup mode after power-up.
// [RULE_14] Single mode holds output until flag cleared.
`timescale 1ns/1ps
module rtc_alarm_gate #(
   parameter int TICKS_PER_SECOND = rtc_alarm_pkg::TICKS_PER_SECOND
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic osc_clk,
   input wire logic main_above_reset,
   input wire logic main_above_battery,
   input wire logic main_above_trip,
   output logic bus_access_ok,
   output logic on_battery,
   output logic alarm_out_pin_o,
   output logic alarm_out_pin_oe,
   output logic irq
);
   // Match registers, indexed second, minute, hour, date, month, weekday.
   logic [7:0] match_ff [6];
   logic [7:0] nxt_match [6];
   logic [7:0] control_ff; // Enable, repeat and backup mode bits.
   logic [7:0] nxt_control;
   logic [1:0] status_ff; // Sticky events, cleared by a read.
   logic [1:0] nxt_status;
   logic [1:0] mask_ff; // Interrupt mask, same layout as status.
   logic [1:0] nxt_mask;
   logic alarm_low_ff; // Open-drain pin is pulled low while set.
   logic nxt_alarm_low;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic [15:0] div_ff; // Divides the oscillator down to one second.
   logic [15:0] nxt_div;
   rtc_alarm_pkg::supply_t supply_s;
   rtc_alarm_pkg::bcd_time_t now;
   logic [2:0] supply_raw;
   logic [2:0] supply_sync;
   logic osc_rise;
   logic sec_tick;
   logic [5:0] carry;
   logic [5:0] step;
   logic [5:0] load;
   logic [7:0] field [6];
   logic [7:0] first_v [6];
   logic [7:0] last_v [6];
   logic [7:0] now_v [6];
   logic rollover;
   logic all_match;
   logic alarm_event;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic check_ff; // High on the first cycle of each new second.
   logic nxt_check;
   logic rd_setup; // Setup cycle of a read, where read data is captured.

   // Oscillator clock and the supply comparators are asynchronous: two flops each.
   edge_sync #(.WIDTH(1)) u_osc_sync (
      .pclk(pclk), .presetn(presetn), .async_in(osc_clk), .sync_out(), .rise_pulse(osc_rise)
   );
   assign supply_raw = {main_above_reset, main_above_battery, main_above_trip};
   edge_sync #(.WIDTH(3)) u_supply_sync (
      .pclk(pclk), .presetn(presetn), .async_in(supply_raw), .sync_out(supply_sync), .rise_pulse()
   );
   assign supply_s = rtc_alarm_pkg::supply_t'(supply_sync);

   // Bus gating. Standard mode switches at the trip level, legacy when main falls under battery.
   always_comb begin
      if (control_ff[rtc_alarm_pkg::CTRL_SWITCH_MODE_BIT]) begin
         on_battery = !supply_s.main_above_battery; // RULE_03
      end else begin
         on_battery = !supply_s.main_above_trip; // RULE_02
      end
      if (!supply_s.main_above_reset) begin
         bus_access_ok = 1'b0; // RULE_01
      end else if (!control_ff[rtc_alarm_pkg::CTRL_SWITCH_MODE_BIT]) begin
         // Both standard modes: the reset threshold is reached before switchover.
         bus_access_ok = !on_battery; // RULE_02 RULE_04
      end else if (!control_ff[rtc_alarm_pkg::CTRL_BUS_IN_BACKUP_BIT]) begin
         bus_access_ok = 1'b1; // RULE_03
      end else begin
         bus_access_ok = supply_s.main_above_battery; // RULE_05
      end
   end

   // Seconds prescaler on oscillator edges.
   always_comb begin
      nxt_div = div_ff;
      sec_tick = 1'b0;
      if (osc_rise) begin
         if (div_ff == 16'(TICKS_PER_SECOND - 1)) begin
            nxt_div = 16'h0000;
            sec_tick = 1'b1;
         end else begin
            nxt_div = div_ff + 16'h0001;
         end
      end
   end

   // Time fields: a simple calendar with 31 days in every month.
   assign first_v[0] = 8'h00;
   assign last_v[0] = rtc_alarm_pkg::SECONDS_LAST_BCD;
   assign first_v[1] = 8'h00;
   assign last_v[1] = 8'h59;
   assign first_v[2] = 8'h00;
   assign last_v[2] = 8'h23;
   assign first_v[3] = 8'h01;
   assign last_v[3] = 8'h31;
   assign first_v[4] = 8'h01;
   assign last_v[4] = 8'h12;
   assign first_v[5] = 8'h00;
   assign last_v[5] = 8'h06;
   assign step[0] = sec_tick;
   assign step[1] = carry[0];
   assign step[2] = carry[1];
   assign step[3] = carry[2];
   assign step[4] = carry[3];
   assign step[5] = carry[2];
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_field
         assign load[gi] = wr_en && (paddr == rtc_alarm_pkg::OFF_TIME_LO || paddr == rtc_alarm_pkg::OFF_TIME_HI)
                           && (paddr == rtc_alarm_pkg::OFF_TIME_HI) == (gi >= 4);
         bcd_counter u_cnt (
            .pclk(pclk), .presetn(presetn), .step(step[gi]), .load(load[gi]),
            .load_value(pwdata[8*(gi%4) +: 8]), .first_value(first_v[gi]), .last_value(last_v[gi]),
            .count(now_v[gi]), .carry(carry[gi])
         );
      end
   endgenerate
   assign now = {now_v[5], now_v[4], now_v[3], now_v[2], now_v[1], now_v[0]};

   // Alarm comparison: disabled fields always agree.
   always_comb begin
      all_match = 1'b1;
      for (int i = 0; i < 6; i++) begin
         field[i] = {1'b0, match_ff[i][rtc_alarm_pkg::MATCH_EN_BIT-1:0]}; // RULE_06
         if (match_ff[i][rtc_alarm_pkg::MATCH_EN_BIT] && (field[i] != now_v[i])) begin
            all_match = 1'b0; // RULE_07
         end
      end
   end
   // The check is taken on the first cycle of the new time, just after the tick.
   assign rollover = sec_tick;
   // Delay the check by one cycle so that the counters already show the new second.
   always_comb begin
      nxt_check = rollover;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         check_ff <= 1'b0;
      end else begin
         check_ff <= nxt_check;
      end
   end
   assign alarm_event = check_ff && all_match && control_ff[rtc_alarm_pkg::CTRL_ALARM0_EN_BIT]; // RULE_08 RULE_09

   // APB decode; zero wait states, unmapped addresses answer with an error.
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign addr_ok = (paddr <= rtc_alarm_pkg::OFF_TIME_HI) && (paddr[1:0] == 2'b00);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   // Register writes, sticky status and alarm pin.
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         nxt_match[i] = match_ff[i];
         if (wr_en && pstrb[0] && paddr == 8'(4 * i)) begin
            nxt_match[i] = pwdata[7:0];
         end
      end
      nxt_control = control_ff;
      if (wr_en && pstrb[0] && paddr == rtc_alarm_pkg::OFF_CONTROL) begin
         nxt_control = pwdata[7:0];
      end
      nxt_mask = mask_ff;
      if (wr_en && pstrb[0] && paddr == rtc_alarm_pkg::OFF_IRQ_MASK) begin
         nxt_mask = pwdata[1:0];
      end
      nxt_status = status_ff;
      // Only the bits already captured for the reader are cleared; an event that arrives
      // between setup and access would otherwise be lost without ever being seen.
      if (rd_en && paddr == rtc_alarm_pkg::OFF_STATUS) begin
         nxt_status = status_ff & ~prdata_ff[1:0];
      end
      // A new event wins over a clearing read in the same cycle.
      if (alarm_event) begin
         nxt_status[rtc_alarm_pkg::STAT_ALARM0_BIT] = 1'b1; // RULE_09 RULE_12
      end
      if (sec_tick) begin
         nxt_status[rtc_alarm_pkg::STAT_SECOND_BIT] = 1'b1;
      end
      nxt_alarm_low = alarm_low_ff;
      if (control_ff[rtc_alarm_pkg::CTRL_REPEAT_BIT]) begin
         // Repeat mode: a one-cycle pulse on every match, flag not needed.
         nxt_alarm_low = alarm_event; // RULE_11
      end else if (alarm_event) begin
         nxt_alarm_low = 1'b1; // RULE_10
      end else if (!nxt_status[rtc_alarm_pkg::STAT_ALARM0_BIT]) begin
         nxt_alarm_low = 1'b0; // RULE_14
      end
      // Read data is captured in the setup cycle so that it stands from a flop in the access cycle.
      nxt_prdata = prdata_ff;
      if (rd_setup) begin
         nxt_prdata = 32'h0000_0000;
         case (paddr)
            rtc_alarm_pkg::OFF_CONTROL: nxt_prdata = {24'h000000, control_ff};
            rtc_alarm_pkg::OFF_STATUS: nxt_prdata = {30'h00000000, status_ff};
            rtc_alarm_pkg::OFF_IRQ_MASK: nxt_prdata = {30'h00000000, mask_ff};
            rtc_alarm_pkg::OFF_POWER: nxt_prdata = {30'h00000000, on_battery, bus_access_ok};
            rtc_alarm_pkg::OFF_TIME_LO: nxt_prdata = {now.hour, now.minute, now.second, 8'h00} >> 8
                                                     | {now.date, 24'h000000};
            rtc_alarm_pkg::OFF_TIME_HI: nxt_prdata = {16'h0000, now.weekday, now.month};
            default: begin
               if (paddr < rtc_alarm_pkg::OFF_CONTROL) begin
                  nxt_prdata = {24'h000000, match_ff[paddr[4:2]]};
               end
            end
         endcase
      end
   end

   // Register the software visible state other than the time counters; defaults give standard backup mode.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 6; i++) begin
            match_ff[i] <= rtc_alarm_pkg::MATCH_RESET;
         end
         control_ff <= rtc_alarm_pkg::CONTROL_RESET; // RULE_13
         mask_ff <= rtc_alarm_pkg::IRQ_MASK_RESET;
         status_ff <= 2'b00;
         alarm_low_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
         div_ff <= 16'h0000;
      end else begin
         match_ff <= nxt_match;
         control_ff <= nxt_control;
         mask_ff <= nxt_mask;
         status_ff <= nxt_status;
         alarm_low_ff <= nxt_alarm_low;
         prdata_ff <= nxt_prdata;
         div_ff <= nxt_div;
      end
   end

   // Read data comes from the flop loaded in the setup cycle, so zero-wait reads still work.
   assign prdata = prdata_ff;
   assign alarm_out_pin_o = 1'b0;
   assign alarm_out_pin_oe = alarm_low_ff;
   assign irq = |(status_ff & mask_ff);

   // Assertions.
   a_bus_reset_off: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
      !supply_s.main_above_reset |-> !bus_access_ok) else $error("bus open below reset threshold");
   a_std_backup_off: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
      !control_ff[rtc_alarm_pkg::CTRL_SWITCH_MODE_BIT] && on_battery |-> !bus_access_ok)
      else $error("bus open on backup in standard mode");
   a_legacy_open: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
      control_ff[1:0] == 2'b01 && supply_s.main_above_reset |-> bus_access_ok) else $error("legacy bus closed");
   a_mode_c_same: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
      control_ff[1:0] == 2'b10 |-> bus_access_ok == (supply_s.main_above_reset && supply_s.main_above_trip))
      else $error("mode with bus bit only differs from standard");
   a_mode_d_gate: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
      control_ff[1:0] == 2'b11 && bus_access_ok |-> supply_s.main_above_battery) else $error("bus open on battery");
   a_disabled_field: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
      (match_ff[0] == 8'h00 && match_ff[1] == 8'h00 && match_ff[2] == 8'h00 && match_ff[3] == 8'h00
       && match_ff[4] == 8'h00 && match_ff[5] == 8'h00) |-> all_match) else $error("disabled fields block");
   a_no_enable_no_event: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
      !control_ff[rtc_alarm_pkg::CTRL_ALARM0_EN_BIT] |-> !alarm_event)
      else $error("alarm without enable bit");
   a_event_sets_flag: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09 RULE_12
      alarm_event |=> status_ff[rtc_alarm_pkg::STAT_ALARM0_BIT] && alarm_low_ff)
      else $error("event did not set flag and pin");
   a_single_holds: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10 RULE_14
      !control_ff[rtc_alarm_pkg::CTRL_REPEAT_BIT] && alarm_low_ff && status_ff[rtc_alarm_pkg::STAT_ALARM0_BIT]
      && !(rd_en && paddr == rtc_alarm_pkg::OFF_STATUS) && !wr_en |=> alarm_low_ff)
      else $error("single alarm released early");
   a_repeat_pulse: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
      control_ff[rtc_alarm_pkg::CTRL_REPEAT_BIT] && !alarm_event && !wr_en |=> !alarm_low_ff)
      else $error("repeat pulse too long");
   // A match in repeat mode, with the mode left alone, gives exactly one low cycle on the pin.
   sequence s_repeat_hit;
      control_ff[rtc_alarm_pkg::CTRL_REPEAT_BIT] && alarm_event && !wr_en;
   endsequence
   sequence s_pulse_once;
      alarm_low_ff ##1 !alarm_low_ff;
   endsequence
   a_repeat_once: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
      s_repeat_hit |=> s_pulse_once) else $error("repeat pulse not one cycle");
endmodule : rtc_alarm_gate

// ==== verilog/rtc_alarm_pkg.sv ====
// Package with shared constants, register map and carrier types for the alarm and bus gating block.
package rtc_alarm_pkg;
   // Register byte offsets on the APB slave.
   localparam logic [7:0] OFF_SECOND_MATCH = 8'h00;
   localparam logic [7:0] OFF_MINUTE_MATCH = 8'h04;
   localparam logic [7:0] OFF_HOUR_MATCH = 8'h08;
   localparam logic [7:0] OFF_DATE_MATCH = 8'h0c;
   localparam logic [7:0] OFF_MONTH_MATCH = 8'h10;
   localparam logic [7:0] OFF_WEEKDAY_MATCH = 8'h14;
   localparam logic [7:0] OFF_CONTROL = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1c;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
   localparam logic [7:0] OFF_POWER = 8'h24;
   localparam logic [7:0] OFF_TIME_LO = 8'h28;
   localparam logic [7:0] OFF_TIME_HI = 8'h2c;
   // Field positions.
   localparam int MATCH_EN_BIT = 7;
   localparam int CTRL_ALARM0_EN_BIT = 5;
   localparam int CTRL_REPEAT_BIT = 7;
   localparam int CTRL_BUS_IN_BACKUP_BIT = 1;
   localparam int CTRL_SWITCH_MODE_BIT = 0;
   localparam int STAT_ALARM0_BIT = 0;
   localparam int STAT_SECOND_BIT = 1;
   // Seconds value at which the minute rolls over.
   localparam logic [7:0] SECONDS_LAST_BCD = 8'h59;
   // Reset values.
   localparam logic [7:0] MATCH_RESET = 8'h00;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
   // Link timebase: 1 Hz tick period in link clock edges (32768 Hz crystal).
   localparam int TICKS_PER_SECOND = 32768;
   // Time of day carried as BCD fields.
   typedef struct packed {
      logic [7:0] weekday;
      logic [7:0] month;
      logic [7:0] date;
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] second;
   } bcd_time_t;
   // Supply comparator results from the analog front end.
   typedef struct packed {
      logic main_above_reset;
      logic main_above_battery;
      logic main_above_trip;
   } supply_t;
endpackage : rtc_alarm_pkg
